// ---- src/clk_cfg_pkg.sv ----
/*
  Package for the PLL and divider configuration bank: register offsets,
  field positions, reset values and decode constants.
  Assumes an APB slave with 32-bit data, one register per aligned word.
*/
package clk_cfg_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PRESCALER  = 8'h35;
  localparam logic [7:0] IDX_MULT_UPPER = 8'h36;
  localparam logic [7:0] IDX_FRAC_LOW   = 8'h37;
  localparam logic [7:0] IDX_INT_LOW    = 8'h38;
  localparam logic [7:0] IDX_N_PDM      = 8'h39;
  localparam logic [7:0] IDX_M_ADC      = 8'h3a;
  localparam logic [7:0] IDX_CONTROL    = 8'h40;
  localparam logic [7:0] IDX_STATUS     = 8'h41;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PRESCALER  = 8'h01;
  localparam logic [7:0] RST_MULT_UPPER = 8'h00;
  localparam logic [7:0] RST_FRAC_LOW   = 8'h00;
  localparam logic [7:0] RST_INT_LOW    = 8'h08;
  localparam logic [7:0] RST_N_PDM      = 8'h20;
  localparam logic [7:0] RST_M_ADC      = 8'h04;
  localparam logic [7:0] RST_CONTROL    = 8'h00;

  // ----------------------------------------------------------------
  // Field positions and writable masks
  // ----------------------------------------------------------------
  localparam int         POS_INT_TOP    = 7;
  localparam int         POS_HALVE      = 6;
  localparam int         POS_CTRL_AUTO  = 0;
  localparam logic [7:0] MASK_N_PDM     = 8'hfc;
  localparam logic [7:0] MASK_CONTROL   = 8'h01;

  // ----------------------------------------------------------------
  // Decode limits
  // ----------------------------------------------------------------
  localparam logic [13:0] FRAC_MAX      = 14'h270f;
  localparam logic [2:0]  PDM_CODE_MAX  = 3'h4;
  localparam logic [1:0]  ADC_CODE_MAX  = 2'h2;

  // Auto-detected settings used while automatic detection runs
  localparam logic [8:0]  AUTO_PRESCALE = 9'h001;
  localparam logic [8:0]  AUTO_INT_MULT = 9'h008;
  localparam logic [13:0] AUTO_FRAC     = 14'h0000;
  localparam logic [3:0]  AUTO_N_DIV    = 4'h1;
  localparam logic [6:0]  AUTO_M_DIV    = 7'h01;

endpackage

// ---- src/clk_cfg_if.sv ----
/*
  Interface carrying the raw divider codes from the register bank to the
  settings decoder and the decoded ratios back. Assumes a single pclk domain.
*/
`timescale 1ns/1ps
interface clk_cfg_if;
  logic [7:0] prescale_code;
  logic [8:0] int_mult_code;
  logic [13:0] frac_code;
  logic [2:0] n_code;
  logic [2:0] pdm_code;
  logic [5:0] m_code;
  logic [1:0] adc_code;
  logic [8:0] prescale_div;
  logic [8:0] int_mult;
  logic [13:0] frac_mult;
  logic [3:0] n_div;
  logic [4:0] pdm_clock_divider;
  logic [6:0] m_div;
  logic [2:0] adc_div;
  logic       code_err;

  modport bank (output prescale_code, int_mult_code, frac_code, n_code, pdm_code, m_code, adc_code,
                input prescale_div, int_mult, frac_mult, n_div, pdm_clock_divider, m_div, adc_div, code_err);
  modport dec  (input prescale_code, int_mult_code, frac_code, n_code, pdm_code, m_code, adc_code,
                output prescale_div, int_mult, frac_mult, n_div, pdm_clock_divider, m_div, adc_div, code_err);
endinterface

// ---- src/clk_cfg_decode.sv ----
/*
  Combinational decoder turning raw divider codes into division ratios.
  Assumes codes come from registers on the same clock.
*/
`timescale 1ns/1ps
module clk_cfg_decode
  import clk_cfg_pkg::*;
(
  clk_cfg_if.dec cfg
);

  // ----------------------------------------------------------------
  // Code to ratio mapping
  // ----------------------------------------------------------------
  always_comb begin
    cfg.prescale_div = (cfg.prescale_code == 8'h00) ? 9'h100 : {1'b0, cfg.prescale_code};
    cfg.int_mult     = cfg.int_mult_code;
    cfg.frac_mult    = cfg.frac_code;
    cfg.n_div        = (cfg.n_code == 3'h0) ? 4'h8 : {1'b0, cfg.n_code};
    cfg.pdm_clock_divider      = (cfg.pdm_code <= PDM_CODE_MAX) ? 5'(5'h01 << cfg.pdm_code) : 5'h00;
    cfg.m_div        = (cfg.m_code == 6'h00) ? 7'h40 : {1'b0, cfg.m_code};
    cfg.adc_div      = (cfg.adc_code <= ADC_CODE_MAX) ? 3'(3'h1 << cfg.adc_code) : 3'h0;
    // Reserved codes flagged so software can see its own mistake
    cfg.code_err     = (cfg.int_mult_code == 9'h000) || (cfg.frac_code > FRAC_MAX)
                       || (cfg.pdm_code > PDM_CODE_MAX) || (cfg.adc_code > ADC_CODE_MAX);
  end

endmodule

// ---- src/pll_and_divider_config.sv ----
/*
  PLL and divider configuration bank with an APB slave.
  Assumes an APB master on pclk; outputs feed the clock generator.
*/
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module pll_and_divider_config
  import clk_cfg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic [8:0]       prescale_div,
  output logic [8:0]       int_mult,
  output logic [13:0]      frac_mult,
  output logic             pll_halve_output,
  output logic [3:0]       n_div,
  output logic [4:0]       pdm_clock_divider,
  output logic [6:0]       m_div,
  output logic [2:0]       adc_div,
  output logic             auto_detect_active
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]  pll_prescaler_cfg;
  logic [7:0]  pll_multiplier_upper_cfg;
  logic [7:0]  pll_fraction_low_cfg;
  logic [7:0]  pll_integer_low_cfg;
  logic [7:0]  n_and_pdm_divider_cfg;
  logic [7:0]  m_and_adc_mod_divider_cfg;
  logic [7:0]  control;
  logic [7:0]  next_pll_prescaler_cfg;
  logic [7:0]  next_pll_multiplier_upper_cfg;
  logic [7:0]  next_pll_fraction_low_cfg;
  logic [7:0]  next_pll_integer_low_cfg;
  logic [7:0]  next_n_and_pdm_divider_cfg;
  logic [7:0]  next_m_and_adc_mod_divider_cfg;
  logic [7:0]  next_control;
  logic        next_pready;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [9:0]  word_idx;
  logic        access;
  logic        wr_en;
  logic        hit;
  logic [7:0]  rd_byte;
  logic [8:0]  next_prescale_div;
  logic [8:0]  next_int_mult;
  logic [13:0] next_frac_mult;
  logic        next_halve;
  logic [3:0]  next_n_div;
  logic [4:0]  next_pdm_clock_divider;
  logic [6:0]  next_m_div;
  logic [2:0]  next_adc_div;
  logic        auto_on;

  clk_cfg_if cfg ();

  // ----------------------------------------------------------------
  // Code decoder
  // ----------------------------------------------------------------
  clk_cfg_decode clk_cfg_decode_i (
    .cfg (cfg.dec)
  );

  // Raw codes gathered from the register fields
  assign cfg.prescale_code = pll_prescaler_cfg;
  assign cfg.int_mult_code = {pll_multiplier_upper_cfg[POS_INT_TOP], pll_integer_low_cfg};
  assign cfg.frac_code     = {pll_multiplier_upper_cfg[5:0], pll_fraction_low_cfg};
  assign cfg.n_code        = n_and_pdm_divider_cfg[7:5];
  assign cfg.pdm_code      = n_and_pdm_divider_cfg[4:2];
  assign cfg.m_code        = m_and_adc_mod_divider_cfg[7:2];
  assign cfg.adc_code      = m_and_adc_mod_divider_cfg[1:0];
  assign auto_on           = control[POS_CTRL_AUTO];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Single-cycle access phase: pready rises one edge after setup
  always_comb begin
    word_idx = paddr[11:2];
    access   = psel && !penable;
    wr_en    = psel && penable && pready && pwrite && pstrb[0];
    hit      = 1'b1;
    if (word_idx == {2'b00, IDX_PRESCALER}) begin
      rd_byte = pll_prescaler_cfg;
    end else if (word_idx == {2'b00, IDX_MULT_UPPER}) begin
      rd_byte = pll_multiplier_upper_cfg;
    end else if (word_idx == {2'b00, IDX_FRAC_LOW}) begin
      rd_byte = pll_fraction_low_cfg;
    end else if (word_idx == {2'b00, IDX_INT_LOW}) begin
      rd_byte = pll_integer_low_cfg;
    end else if (word_idx == {2'b00, IDX_N_PDM}) begin
      rd_byte = n_and_pdm_divider_cfg & MASK_N_PDM;
    end else if (word_idx == {2'b00, IDX_M_ADC}) begin
      rd_byte = m_and_adc_mod_divider_cfg;
    end else if (word_idx == {2'b00, IDX_CONTROL}) begin
      rd_byte = control & MASK_CONTROL;
    end else if (word_idx == {2'b00, IDX_STATUS}) begin
      rd_byte = {6'h00, cfg.code_err, auto_on};
    end else begin
      rd_byte = 8'h00;
      hit     = 1'b0;
    end
    next_pready  = access;
    next_prdata  = (access && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    next_pslverr = access && !hit;
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Writes land only at the completing edge; status is read-only
  always_comb begin
    next_pll_prescaler_cfg         = pll_prescaler_cfg;
    next_pll_multiplier_upper_cfg  = pll_multiplier_upper_cfg;
    next_pll_fraction_low_cfg      = pll_fraction_low_cfg;
    next_pll_integer_low_cfg       = pll_integer_low_cfg;
    next_n_and_pdm_divider_cfg     = n_and_pdm_divider_cfg;
    next_m_and_adc_mod_divider_cfg = m_and_adc_mod_divider_cfg;
    next_control                   = control;
    if (wr_en) begin
      if (word_idx == {2'b00, IDX_PRESCALER}) begin
        next_pll_prescaler_cfg = pwdata[7:0];
      end else if (word_idx == {2'b00, IDX_MULT_UPPER}) begin
        next_pll_multiplier_upper_cfg = pwdata[7:0];
      end else if (word_idx == {2'b00, IDX_FRAC_LOW}) begin
        next_pll_fraction_low_cfg = pwdata[7:0];
      end else if (word_idx == {2'b00, IDX_INT_LOW}) begin
        next_pll_integer_low_cfg = pwdata[7:0];
      end else if (word_idx == {2'b00, IDX_N_PDM}) begin
        // Read-only low bits keep their reset value
        next_n_and_pdm_divider_cfg = (pwdata[7:0] & MASK_N_PDM) | (RST_N_PDM & ~MASK_N_PDM);
      end else if (word_idx == {2'b00, IDX_M_ADC}) begin
        next_m_and_adc_mod_divider_cfg = pwdata[7:0];
      end else if (word_idx == {2'b00, IDX_CONTROL}) begin
        next_control = pwdata[7:0] & MASK_CONTROL;
      end
    end
  end

  // ----------------------------------------------------------------
  // Effective settings
  // ----------------------------------------------------------------
  // Auto mode overrides every programmed field except the halving bit so a half-written
  // configuration never reaches the clock tree
  always_comb begin
    if (auto_on) begin
      next_prescale_div = AUTO_PRESCALE;
      next_int_mult     = AUTO_INT_MULT;
      next_frac_mult    = AUTO_FRAC;
      next_n_div        = AUTO_N_DIV;
      next_pdm_clock_divider      = 5'h01;
      next_m_div        = AUTO_M_DIV;
      next_adc_div      = 3'h1;
    end else begin
      next_prescale_div = cfg.prescale_div;
      next_int_mult     = cfg.int_mult;
      next_frac_mult    = cfg.frac_mult;
      next_n_div        = cfg.n_div;
      next_pdm_clock_divider      = cfg.pdm_clock_divider;
      next_m_div        = cfg.m_div;
      next_adc_div      = cfg.adc_div;
    end
    next_halve = pll_multiplier_upper_cfg[POS_HALVE];
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_prescaler_cfg         <= RST_PRESCALER;
      pll_multiplier_upper_cfg  <= RST_MULT_UPPER;
      pll_fraction_low_cfg      <= RST_FRAC_LOW;
      pll_integer_low_cfg       <= RST_INT_LOW;
      n_and_pdm_divider_cfg     <= RST_N_PDM;
      m_and_adc_mod_divider_cfg <= RST_M_ADC;
      control                   <= RST_CONTROL;
      pready                    <= 1'b0;
      prdata                    <= 32'h00000000;
      pslverr                   <= 1'b0;
      prescale_div              <= 9'h001;
      int_mult                  <= 9'h008;
      frac_mult                 <= 14'h0000;
      pll_halve_output          <= 1'b0;
      n_div                     <= 4'h1;
      pdm_clock_divider                   <= 5'h01;
      m_div                     <= 7'h01;
      adc_div                   <= 3'h1;
      auto_detect_active        <= 1'b0;
    end else if (clk_en) begin
      pll_prescaler_cfg         <= next_pll_prescaler_cfg;
      pll_multiplier_upper_cfg  <= next_pll_multiplier_upper_cfg;
      pll_fraction_low_cfg      <= next_pll_fraction_low_cfg;
      pll_integer_low_cfg       <= next_pll_integer_low_cfg;
      n_and_pdm_divider_cfg     <= next_n_and_pdm_divider_cfg;
      m_and_adc_mod_divider_cfg <= next_m_and_adc_mod_divider_cfg;
      control                   <= next_control;
      pready                    <= next_pready;
      prdata                    <= next_prdata;
      pslverr                   <= next_pslverr;
      prescale_div              <= next_prescale_div;
      int_mult                  <= next_int_mult;
      frac_mult                 <= next_frac_mult;
      pll_halve_output          <= next_halve;
      n_div                     <= next_n_div;
      pdm_clock_divider                   <= next_pdm_clock_divider;
      m_div                     <= next_m_div;
      adc_div                   <= next_adc_div;
      auto_detect_active        <= auto_on;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence apb_setup_s;
    psel && !penable;
  endsequence

  sequence apb_access_s;
    psel && penable && pready;
  endsequence

  // Completing edge of a write: the only edge at which a register changes
  sequence apb_write_s;
    psel && penable && pready && pwrite && pstrb[0];
  endsequence

  // Output checks accept a frozen next edge: with clk_en low the outputs
  // keep their old value, which the codes sampled a cycle earlier need not
  // match any more
  AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en and apb_setup_s) |=> pready)
    else $error("pready missing after setup");

  AST_PRESCALE_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !auto_on && pll_prescaler_cfg == 8'h00 |=> !clk_en || prescale_div == 9'h100)
    else $error("prescale zero not 256");

  AST_AUTO_OVERRIDE: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && auto_on |=> !clk_en || (int_mult == AUTO_INT_MULT && m_div == AUTO_M_DIV))
    else $error("auto mode not overriding");

  AST_INT_MULT: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !auto_on |=> !clk_en || int_mult == $past(cfg.int_mult_code))
    else $error("integer multiplier wrong");

  AST_HALVE: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> !clk_en || pll_halve_output == $past(pll_multiplier_upper_cfg[6]))
    else $error("halve bit not followed");

  AST_N_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !auto_on && n_and_pdm_divider_cfg[7:5] == 3'h0 |=> !clk_en || n_div == 4'h8)
    else $error("N zero not 8");

  AST_M_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !auto_on && m_and_adc_mod_divider_cfg[7:2] == 6'h00 |=> !clk_en || m_div == 7'h40)
    else $error("M zero not 64");

  AST_PDM_MAP: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !auto_on && n_and_pdm_divider_cfg[4:2] == 3'h4 |=> !clk_en || pdm_clock_divider == 5'h10)
    else $error("PDM code 4 not 16");

  AST_ADC_MAP: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !auto_on && m_and_adc_mod_divider_cfg[1:0] == 2'h2 |=> !clk_en || adc_div == 3'h4)
    else $error("ADC code 2 not 4");

  AST_RESERVED_RO: assert property (@(posedge pclk) disable iff (!presetn)
    n_and_pdm_divider_cfg[1:0] == 2'b00)
    else $error("reserved bits changed");

  AST_RESERVED_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !pwrite && paddr[11:2] == {2'b00, IDX_N_PDM}) and apb_setup_s
      |=> apb_access_s and (prdata[1:0] == 2'b00))
    else $error("reserved bits read nonzero");

  // Whatever software puts in the low bits, they keep their reset value
  AST_N_PDM_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && paddr[11:2] == {2'b00, IDX_N_PDM}) and apb_write_s
      |=> n_and_pdm_divider_cfg == {$past(pwdata[7:2]), 2'b00})
    else $error("N and PDM write not masked");

  AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !hit) and apb_setup_s |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");

  // ----------------------------------------------------------------
  // Field mapping assertions
  // ----------------------------------------------------------------
  // One check per class of code, seen one enabled edge after the register
  AST_PRESCALE_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !auto_on && pll_prescaler_cfg != 8'h00
      |=> !clk_en || prescale_div == {1'b0, $past(pll_prescaler_cfg)})
    else $error("prescale code not passed");

  AST_FRAC: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !auto_on |=> !clk_en || frac_mult == $past(cfg.frac_code))
    else $error("fraction wrong");

  AST_N_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !auto_on && cfg.n_code != 3'h0 |=> !clk_en || n_div == {1'b0, $past(cfg.n_code)})
    else $error("N code not passed");

  AST_M_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !auto_on && cfg.m_code != 6'h00 |=> !clk_en || m_div == {1'b0, $past(cfg.m_code)})
    else $error("M code not passed");

  AST_PDM_EIGHT: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !auto_on && cfg.pdm_code == 3'h3 |=> !clk_en || pdm_clock_divider == 5'h08)
    else $error("PDM code 3 not 8");

  AST_ADC_TWO: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !auto_on && cfg.adc_code == 2'h1 |=> !clk_en || adc_div == 3'h2)
    else $error("ADC code 1 not 2");

  // The five other overridden fields, beyond the two that the first check covers
  AST_AUTO_REST: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && auto_on |=> !clk_en || (prescale_div == AUTO_PRESCALE && frac_mult == AUTO_FRAC
      && n_div == AUTO_N_DIV && pdm_clock_divider == 5'h01 && adc_div == 3'h1))
    else $error("auto mode left a field programmed");

endmodule

// ---- dv/pll_and_divider_config_tb_top.sv ----
/*
  Self-checking bench for the PLL and divider configuration bank.
  Assumes the design package clk_cfg_pkg, a single pclk domain and zero-wait APB answers.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module pll_and_divider_config_tb_top
  import clk_cfg_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        clk_en  = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  pstrb   = 4'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [8:0]  prescale_div;
  logic [8:0]  int_mult;
  logic [13:0] frac_mult;
  logic        pll_halve_output;
  logic [3:0]  n_div;
  logic [4:0]  pdm_clock_divider;
  logic [6:0]  m_div;
  logic [2:0]  adc_div;
  logic        auto_detect_active;
  int          fails      = 0;
  int          num_checks = 0;

  // Clock at 125 MHz
  always #4 pclk = ~pclk;

  pll_and_divider_config pll_and_divider_config_i (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .prescale_div(prescale_div), .int_mult(int_mult),
    .frac_mult(frac_mult), .pll_halve_output(pll_halve_output), .n_div(n_div),
    .pdm_clock_divider(pdm_clock_divider), .m_div(m_div), .adc_div(adc_div), .auto_detect_active(auto_detect_active)
  );

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] st, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h0, d};
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // No local limit: a slave that never answers is caught by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
  endtask

  // Write, then let the outputs follow one edge later
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, d, 4'hf, rd, err);
    @(posedge pclk);
    #1;
  endtask

  task automatic rdr(input logic [7:0] idx, output logic [31:0] v);
    logic err;
    apb(1'b0, idx, 8'h00, 4'h0, v, err);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values at the outputs and through readback
  task automatic t_reset();
    logic [7:0]  ridx [6] = '{IDX_PRESCALER, IDX_MULT_UPPER, IDX_FRAC_LOW, IDX_INT_LOW, IDX_N_PDM, IDX_M_ADC};
    logic [7:0]  rval [6] = '{8'h01, 8'h00, 8'h00, 8'h08, 8'h20, 8'h04};
    logic [31:0] v;
    `CHK(int_mult, 9'h008)
    `CHK(prescale_div, 9'h001)
    `CHK(n_div, 4'h1)
    `CHK(m_div, 7'h01)
    `CHK(pll_halve_output, 1'b0)
    for (int i = 0; i < 6; i++) begin
      rdr(ridx[i], v);
      `CHK(v, {24'h0, rval[i]})
    end
    $display("test reset done");
  endtask

  // Pre-scaler including the zero code and the top code
  task automatic t_prescale();
    logic [7:0]  codes [4] = '{8'h00, 8'h01, 8'h02, 8'hff};
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      wr(IDX_PRESCALER, codes[i]);
      `CHK(prescale_div, (codes[i] == 8'h00) ? 9'h100 : {1'b0, codes[i]})
      rdr(IDX_PRESCALER, v);
      `CHK(v, {24'h0, codes[i]})
    end
    $display("test prescale done");
  endtask

  // Integer and fractional multipliers and the halving bit share one register
  task automatic t_mult();
    wr(IDX_INT_LOW, 8'hff);
    wr(IDX_MULT_UPPER, 8'hc0);
    `CHK(int_mult, 9'h1ff)
    `CHK(pll_halve_output, 1'b1)
    wr(IDX_MULT_UPPER, 8'h27);
    wr(IDX_FRAC_LOW, 8'h0f);
    `CHK(frac_mult, 14'h270f)
    `CHK(int_mult, 9'h0ff)
    `CHK(pll_halve_output, 1'b0)
    wr(IDX_INT_LOW, 8'h01); // Never zero: that code is reserved
    `CHK(int_mult, 9'h001)
    wr(IDX_INT_LOW, 8'h08);
    $display("test mult done");
  endtask

  // N sweeps all codes while PDM walks its legal codes
  task automatic t_n_pdm();
    logic [2:0]  p;
    logic [31:0] v;
    for (int i = 0; i < 8; i++) begin
      p = 3'(i % 5);
      wr(IDX_N_PDM, {3'(i), p, 2'b00});
      `CHK(n_div, (i == 0) ? 4'h8 : 4'(i))
      `CHK(pdm_clock_divider, 5'h01 << p)
    end
    // Reserved low bits must read back as zero
    wr(IDX_N_PDM, 8'hf3);
    rdr(IDX_N_PDM, v);
    `CHK(v, 32'h000000f0)
    `CHK(n_div, 4'h7)
    wr(IDX_N_PDM, 8'h20);
    $display("test n_pdm done");
  endtask

  // M boundary codes with every legal ADC modulator code
  task automatic t_m_adc();
    logic [5:0] m [4] = '{6'h00, 6'h01, 6'h02, 6'h3f};
    logic [1:0] a;
    for (int i = 0; i < 4; i++) begin
      a = 2'(i % 3);
      wr(IDX_M_ADC, {m[i], a});
      `CHK(m_div, (m[i] == 6'h00) ? 7'h40 : {1'b0, m[i]})
      `CHK(adc_div, 3'h1 << a)
    end
    $display("test m_adc done");
  endtask

  // Automatic detection overrides every programmed field but the halving bit
  task automatic t_auto();
    wr(IDX_PRESCALER, 8'h05);
    wr(IDX_N_PDM, 8'h4c);
    wr(IDX_MULT_UPPER, 8'h41);
    wr(IDX_CONTROL, 8'h01);
    `CHK(auto_detect_active, 1'b1)
    `CHK({prescale_div, int_mult, frac_mult}, {9'h001, 9'h008, 14'h0000})
    `CHK({n_div, pdm_clock_divider, m_div, adc_div}, {4'h1, 5'h01, 7'h01, 3'h1})
    `CHK(pll_halve_output, 1'b1)
    wr(IDX_CONTROL, 8'h00);
    `CHK({prescale_div, n_div, pdm_clock_divider}, {9'h005, 4'h2, 5'h08})
    `CHK(frac_mult, 14'h010f)
    $display("test auto done");
  endtask

  // Unmapped address and a write without its byte strobe
  task automatic t_refuse();
    logic [31:0] v;
    logic        err;
    apb(1'b1, 8'h3b, 8'hff, 4'hf, v, err);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h3b, 8'h00, 4'h0, v, err);
    `CHK({err, v}, {1'b1, 32'h0})
    apb(1'b1, IDX_PRESCALER, 8'h77, 4'he, v, err);
    rdr(IDX_PRESCALER, v);
    `CHK(v, 32'h00000005)
    $display("test refuse done");
  endtask

  // A committed write must not reach the outputs while clk_en is low
  task automatic t_freeze();
    logic [31:0] v;
    logic        err;
    apb(1'b1, IDX_PRESCALER, 8'h09, 4'hf, v, err);
    clk_en <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK(prescale_div, 9'h005)
    clk_en <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    `CHK(prescale_div, 9'h009)
    $display("test freeze done");
  endtask

  // ----------------------------------------------------------------
  // Closing and main sequence
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the roughly 180 cycles the tests need
  initial begin
    #(5000 * 8);
    fails++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    t_reset();
    t_prescale();
    t_mult();
    t_n_pdm();
    t_m_adc();
    t_auto();
    t_refuse();
    t_freeze();
    print_verdict();
  end
endmodule
